// ---- design/flash_host_pkg.sv ----
// Package with constants, commands and register map of the flash write-status host controller.
// Functional notes
// - Host polls status at an address inside the targeted sector or block.
// - Abort flag clears only by abort-reset command, power cycle or hardware reset.
// - After reset release host waits reset_high_to_read before a valid read.
// - Host sets the restart status flag for a program or erase that a hardware reset interrupted in its sequence or polling; it does not reissue it.
// - Program needs three unlock and command cycles, erase needs six.
// - Upper data byte is not decoded in command cycles but host drives valid levels.
package flash_host_pkg;
    localparam int CLK_MHZ          = 25;
    localparam int STROBE_NS        = 60;
    localparam int READ_CYCLE_NS    = 90;
    localparam int SETUP_NS         = 40;
    localparam int STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC         = (READ_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_PULSE_NS   = 500;
    localparam int RESET_READ_NS    = 50000;
    localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_READ_CYC   = (RESET_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int TIMEOUT_MS       = 1000;
    localparam int TIMEOUT_CYC      = TIMEOUT_MS * CLK_MHZ * 1000;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_CFG    = 8'h10;
    localparam logic [31:0] CFG_RESET = 32'h0000_0001;

    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_ABORT   = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_RESTART = 4;
    localparam int ST_READY   = 5;
    localparam int ST_WP      = 6;

    localparam int BIT_TOGGLE = 6;
    localparam int BIT_ABORT  = 1;

    localparam logic [21:0] UNLOCK_ADDR1 = 22'h00_0555;
    localparam logic [21:0] UNLOCK_ADDR2 = 22'h00_02AA;
    localparam logic [15:0] UNLOCK_DAT1  = 16'h00AA;
    localparam logic [15:0] UNLOCK_DAT2  = 16'h0055;
    localparam logic [15:0] CMD_PROGRAM  = 16'h00A0;
    localparam logic [15:0] CMD_ERASE    = 16'h0080;
    localparam logic [15:0] CMD_SECTOR   = 16'h0050;
    localparam logic [15:0] CMD_BLOCK    = 16'h0030;
    localparam logic [15:0] CMD_CHIP     = 16'h0010;
    localparam logic [15:0] CMD_ABORTRST = 16'h00F0;

    typedef enum logic [2:0] {
        K_NONE  = 3'h0,
        K_PROG  = 3'h1,
        K_SECT  = 3'h2,
        K_BLOCK = 3'h3,
        K_CHIP  = 3'h4,
        K_READ  = 3'h5,
        K_HWRST = 3'h6,
        K_ABRST = 3'h7
    } op_kind_t;
endpackage : flash_host_pkg

// ---- design/flash_cyc_if.sv ----
// Interface carrying single bus-cycle requests from the controller to the pin engine.
`timescale 1ns/1ps
interface flash_cyc_if;
    logic        req;
    logic        wr;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    modport ctrl (output req, output wr, output addr, output wdata, input ack, input rdata);
    modport eng  (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : flash_cyc_if

// ---- design/flash_pin_engine.sv ----
// Pin engine that runs one asynchronous flash read or write cycle per request.
`timescale 1ns/1ps
module flash_pin_engine
    import flash_host_pkg::*;
(
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst,
    flash_cyc_if.eng    cyc,
    input  wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic        o_dq_oe,
    output logic [21:0] o_addr,
    output logic        o_ce_n,
    output logic        o_we_n,
    output logic        o_oe_n
);
    typedef enum logic [1:0] {E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b11, E_HOLD = 2'b10} eng_state_t;
    eng_state_t  state_r;
    logic [3:0]  cnt_r;
    logic        wr_r;
    logic [15:0] dq_meta_r;
    logic [15:0] dq_sync_r;
    logic [15:0] rdata_r;
    logic        ack_r;
    // The read strobe stays low two extra cycles so the synchronised bus is settled when sampled.
    localparam logic [3:0] WR_LEN = 4'(STROBE_CYC);
    localparam logic [3:0] RD_LEN = 4'(READ_CYC + 2);
    wire cnt_end = (cnt_r == 4'h1);

    assign cyc.ack   = ack_r;
    assign cyc.rdata = rdata_r;

    always_ff @(posedge i_sys_clk) begin
        dq_meta_r <= i_dq;
        dq_sync_r <= dq_meta_r;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_r <= E_IDLE;
            cnt_r   <= 4'h0;
            wr_r    <= 1'b0;
            ack_r   <= 1'b0;
            rdata_r <= 16'h0000;
            o_dq    <= 16'h0000;
            o_dq_oe <= 1'b0;
            o_addr  <= 22'h00_0000;
            o_ce_n  <= 1'b1;
            o_we_n  <= 1'b1;
            o_oe_n  <= 1'b1;
        end else begin
            ack_r <= 1'b0;
            unique case (state_r)
                E_IDLE: begin
                    if (cyc.req) begin
                        wr_r    <= cyc.wr;
                        o_addr  <= cyc.addr;
                        o_dq    <= cyc.wdata;
                        o_dq_oe <= cyc.wr;
                        o_ce_n  <= 1'b0;
                        cnt_r   <= 4'(SETUP_CYC);
                        state_r <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    if (cnt_end) begin
                        // Output enable stays high for the whole write cycle.
                        o_we_n  <= ~wr_r;
                        o_oe_n  <= wr_r;
                        // Strobe is held well over the glitch filter width.
                        cnt_r   <= wr_r ? WR_LEN : RD_LEN;
                        state_r <= E_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                E_STROBE: begin
                    if (cnt_end) begin
                        o_we_n  <= 1'b1;
                        o_oe_n  <= 1'b1;
                        rdata_r <= dq_sync_r;
                        state_r <= E_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                E_HOLD: begin
                    o_ce_n  <= 1'b1;
                    o_dq_oe <= 1'b0;
                    ack_r   <= 1'b1;
                    state_r <= E_IDLE;
                end
            endcase
        end
    end
endmodule : flash_pin_engine

// ---- design/flash_host_ctrl.sv ----
// Host controller that issues guarded program, erase and reset sequences and polls flash status.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int RESET_READ_CYCLES = RESET_READ_CYC,
    parameter int TIMEOUT_CYCLES    = TIMEOUT_CYC
)(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic [31:0]      o_reg_rdata,
    input  wire logic [15:0] i_dq,
    output logic [15:0]      o_dq,
    output logic             o_dq_oe,
    output logic [21:0]      o_addr,
    output logic             o_ce_n,
    output logic             o_we_n,
    output logic             o_oe_n,
    output logic             o_wp_n,
    output logic             o_hw_rst_n,
    input  wire logic        i_ready_busy_n
);
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_SEQ    = 3'b001,
        S_POLL   = 3'b011,
        S_READ   = 3'b010,
        S_RST_LO = 3'b110,
        S_RST_HI = 3'b111
    } ctrl_state_t;

    flash_cyc_if cyc ();

    ctrl_state_t  state_r;
    op_kind_t     kind_r;
    logic [21:0]  addr_r;
    logic [15:0]  data_r;
    logic [15:0]  prev_r;
    logic         first_r;
    logic         pend_r;
    logic         req_r;
    logic [2:0]   idx_r;
    logic [31:0]  tmr_r;
    logic [31:0]  cfg_r;
    logic [6:1]   sticky_r;
    logic         rdy_meta_r;
    logic         rdy_sync_r;
    logic         hw_rst_n_r;

    function automatic logic [37:0] seq_word(input op_kind_t k, input logic [2:0] i,
                                             input logic [21:0] a, input logic [15:0] d);
        logic [37:0] w;
        w = {UNLOCK_ADDR1, UNLOCK_DAT1};
        unique case (i)
            3'd0: w = {UNLOCK_ADDR1, UNLOCK_DAT1};
            3'd1: w = {UNLOCK_ADDR2, UNLOCK_DAT2};
            3'd2: w = (k == K_PROG) ? {UNLOCK_ADDR1, CMD_PROGRAM} :
                      (k == K_ABRST) ? {UNLOCK_ADDR1, CMD_ABORTRST} : {UNLOCK_ADDR1, CMD_ERASE};
            3'd3: w = (k == K_PROG) ? {a, d} : {UNLOCK_ADDR1, UNLOCK_DAT1};
            3'd4: w = {UNLOCK_ADDR2, UNLOCK_DAT2};
            default: w = (k == K_SECT) ? {a, CMD_SECTOR} :
                         (k == K_BLOCK) ? {a, CMD_BLOCK} : {UNLOCK_ADDR1, CMD_CHIP};
        endcase
        return w;
    endfunction : seq_word

    // Program is three unlock/command cycles plus data, erase six cycles, abort-reset three.
    wire [2:0] seq_last = (kind_r == K_PROG) ? 3'd3 : (kind_r == K_ABRST) ? 3'd2 : 3'd5;
    wire [37:0] cur_word = seq_word(kind_r, idx_r, addr_r, data_r);
    wire        wr_ctrl  = i_reg_wr && (i_reg_addr == REG_CTRL);
    wire        wr_stat  = i_reg_wr && (i_reg_addr == REG_STATUS);
    wire        busy     = (state_r != S_IDLE);
    wire [2:0]  go_kind  = i_reg_wdata[2:0];
    wire        go       = wr_ctrl && !busy && (go_kind != 3'(K_NONE));
    // A hardware reset request is honoured even mid-operation so a hung device can be recovered.
    wire        go_rst   = wr_ctrl && (go_kind == 3'(K_HWRST));
    wire        toggled  = cyc.rdata[BIT_TOGGLE] != prev_r[BIT_TOGGLE];
    wire        timeout  = (tmr_r == 32'(TIMEOUT_CYCLES));
    wire        seq_done = (state_r == S_SEQ) && cyc.ack && (idx_r == seq_last);
    wire        poll_ack = (state_r == S_POLL) && cyc.ack && !first_r;
    wire        poll_ok  = poll_ack && !toggled;
    // Abort needs the flag on both reads: the first data read after completion also differs.
    wire        poll_abt = poll_ack && toggled && cyc.rdata[BIT_ABORT] && prev_r[BIT_ABORT];
    wire        rst_done = (state_r == S_RST_HI) && (tmr_r == 32'(RESET_READ_CYCLES));

    wire [6:1] sticky_set;
    assign sticky_set[ST_DONE]    = poll_ok || rst_done || ((state_r == S_READ) && cyc.ack) ||
                                    (seq_done && kind_r == K_ABRST);
    assign sticky_set[ST_ABORT]   = poll_abt;
    assign sticky_set[ST_TIMEOUT] = (state_r == S_POLL) && timeout;
    assign sticky_set[ST_RESTART] = go_rst && (state_r == S_SEQ || state_r == S_POLL);
    assign sticky_set[ST_READY]   = 1'b0;
    assign sticky_set[ST_WP]      = 1'b0;

    wire [31:0] status_word = {25'h000_0000, cfg_r[0], rdy_sync_r, sticky_r[ST_RESTART],
                               sticky_r[ST_TIMEOUT], sticky_r[ST_ABORT], sticky_r[ST_DONE], busy};
    wire [31:0] rd_mux = (i_reg_addr == REG_CTRL)   ? {29'h0000_0000, kind_r} :
                         (i_reg_addr == REG_ADDR)   ? {10'h000, addr_r} :
                         (i_reg_addr == REG_DATA)   ? {16'h0000, data_r} :
                         (i_reg_addr == REG_STATUS) ? status_word :
                         (i_reg_addr == REG_CFG)    ? cfg_r : 32'h0000_0000;

    assign cyc.req   = req_r;
    assign cyc.wr    = (state_r == S_SEQ);
    assign cyc.addr  = (state_r == S_SEQ) ? cur_word[37:16] : addr_r;
    // Upper byte of command words is zero, a valid level the device ignores.
    assign cyc.wdata = cur_word[15:0];
    assign o_wp_n     = cfg_r[0];
    assign o_hw_rst_n = hw_rst_n_r;

    flash_pin_engine u_eng (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .cyc       (cyc.eng),
        .i_dq      (i_dq),
        .o_dq      (o_dq),
        .o_dq_oe   (o_dq_oe),
        .o_addr    (o_addr),
        .o_ce_n    (o_ce_n),
        .o_we_n    (o_we_n),
        .o_oe_n    (o_oe_n)
    );

    // Open-drain line: only its level is sampled, through two stages.
    always_ff @(posedge i_sys_clk) begin
        rdy_meta_r <= i_ready_busy_n;
        rdy_sync_r <= rdy_meta_r;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 32'h0000_0000;
            cfg_r       <= CFG_RESET;
            sticky_r    <= 6'h00;
        end else begin
            if (i_reg_rd) begin
                o_reg_rdata <= rd_mux;
            end
            if (i_reg_wr && i_reg_addr == REG_CFG) begin
                // Low write-protect locks the boot block while software keeps it so.
                cfg_r <= {31'h0000_0000, i_reg_wdata[0]};
            end
            // A flag raised in the clearing cycle survives the write-one clear.
            sticky_r <= (sticky_r & ~(wr_stat ? i_reg_wdata[6:1] : 6'h00)) | sticky_set;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_r    <= S_IDLE;
            kind_r     <= K_NONE;
            addr_r     <= 22'h00_0000;
            data_r     <= 16'h0000;
            prev_r     <= 16'h0000;
            first_r    <= 1'b1;
            pend_r     <= 1'b0;
            req_r      <= 1'b0;
            idx_r      <= 3'h0;
            tmr_r      <= 32'h0000_0000;
            hw_rst_n_r <= 1'b1;
        end else begin
            req_r <= 1'b0;
            if (!busy && i_reg_wr && i_reg_addr == REG_ADDR) begin
                addr_r <= i_reg_wdata[21:0];
            end
            if (!busy && i_reg_wr && i_reg_addr == REG_DATA) begin
                data_r <= i_reg_wdata[15:0];
            end
            if (go_rst) begin
                // Hold the reset pin low for the minimum pulse, aborting any operation.
                kind_r     <= K_HWRST;
                hw_rst_n_r <= pend_r && !cyc.ack;
                tmr_r      <= 32'h0000_0000;
                pend_r     <= pend_r && !cyc.ack;
                state_r    <= S_RST_LO;
            end else begin
                unique case (state_r)
                    S_IDLE: begin
                        if (go) begin
                            kind_r  <= op_kind_t'(go_kind);
                            idx_r   <= 3'h0;
                            first_r <= 1'b1;
                            tmr_r   <= 32'h0000_0000;
                            state_r <= (go_kind == 3'(K_READ)) ? S_READ : S_SEQ;
                        end
                    end
                    S_SEQ: begin
                        if (!pend_r) begin
                            req_r  <= 1'b1;
                            pend_r <= 1'b1;
                        end else if (cyc.ack) begin
                            pend_r <= 1'b0;
                            idx_r  <= idx_r + 3'h1;
                            if (seq_done) begin
                                // Status is only trusted after the last strobe of the sequence.
                                state_r <= (kind_r == K_ABRST) ? S_IDLE : S_POLL;
                            end
                        end
                    end
                    S_POLL: begin
                        tmr_r <= tmr_r + 32'h1;
                        if (!pend_r) begin
                            // Polls use the operation's own target address.
                            req_r  <= 1'b1;
                            pend_r <= 1'b1;
                        end else if (cyc.ack) begin
                            pend_r  <= 1'b0;
                            first_r <= 1'b0;
                            prev_r  <= cyc.rdata;
                            if (poll_ok) begin
                                // Two equal toggle reads mean the device is back in read mode.
                                state_r <= S_IDLE;
                            end else if (poll_abt) begin
                                // Abort flag leaves only through the abort-reset command or a hardware reset.
                                kind_r  <= K_ABRST;
                                idx_r   <= 3'h0;
                                state_r <= S_SEQ;
                            end
                        end
                        if (timeout && !cyc.ack) begin
                            pend_r  <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end
                    S_READ: begin
                        if (!pend_r) begin
                            req_r  <= 1'b1;
                            pend_r <= 1'b1;
                        end else if (cyc.ack) begin
                            pend_r  <= 1'b0;
                            data_r  <= cyc.rdata;
                            state_r <= S_IDLE;
                        end
                    end
                    S_RST_LO: begin
                        if (pend_r) begin
                            // A cycle in flight ends first, so no strobe overlaps the pulse.
                            if (cyc.ack) begin
                                pend_r     <= 1'b0;
                                hw_rst_n_r <= 1'b0;
                            end
                        end else begin
                            tmr_r <= tmr_r + 32'h1;
                            if (tmr_r == 32'(RESET_PULSE_CYC - 1)) begin
                                hw_rst_n_r <= 1'b1;
                                tmr_r      <= 32'h0000_0000;
                                state_r    <= S_RST_HI;
                            end
                        end
                    end
                    S_RST_HI: begin
                        // No access until the post-reset read delay has passed.
                        tmr_r <= tmr_r + 32'h1;
                        if (rst_done) begin
                            state_r <= S_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule : flash_host_ctrl

// ---- verification/flash_host_monitor.sv ----
// Checker of the flash pin timing driven by the host controller.
`timescale 1ns/1ps
module flash_host_monitor
    import flash_host_pkg::*;
#(parameter int RESET_READ_CYCLES = 10)(
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic [15:0] o_dq,
    input wire logic        o_dq_oe,
    input wire logic [21:0] o_addr,
    input wire logic        o_ce_n,
    input wire logic        o_we_n,
    input wire logic        o_oe_n,
    input wire logic        o_hw_rst_n
);
    int low_r;
    int high_r;
    always_ff @(posedge i_sys_clk) begin
        low_r  <= (i_rst || o_hw_rst_n) ? 0 : low_r + 1;
        high_r <= (i_rst || !o_hw_rst_n) ? 0 : high_r + 1;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    strobe_excl_a: assert property (!(!o_we_n && !o_oe_n))
        else $error("write and read strobes low together");
    write_in_ce_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
        else $error("write strobe outside a selected write");
    upper_byte_a: assert property (!o_we_n |-> o_dq_oe && (o_dq[15:8] == 8'h00 ||
        (o_addr != UNLOCK_ADDR1 && o_addr != UNLOCK_ADDR2)))
        else $error("upper data byte not driven low in a write");
    we_width_a: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
        else $error("write strobe width wrong");
    read_bus_a: assert property (!o_oe_n |-> !o_dq_oe && !o_ce_n)
        else $error("read with bus driven or chip deselected");
    reset_quiet_a: assert property (!o_hw_rst_n |-> o_we_n && o_oe_n)
        else $error("strobe active during hardware reset");
    reset_pulse_a: assert property ($rose(o_hw_rst_n) |-> low_r >= RESET_PULSE_CYC)
        else $error("hardware reset pulse too short");
    reset_wait_a: assert property ($fell(o_oe_n) |-> high_r >= RESET_READ_CYCLES)
        else $error("read too soon after hardware reset");
endmodule : flash_host_monitor
bind flash_host_ctrl flash_host_monitor #(.RESET_READ_CYCLES(RESET_READ_CYCLES)) u_mon (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_addr(o_addr),
    .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_hw_rst_n(o_hw_rst_n));

// ---- verification/flash_dev_model.sv ----
// Behavioural model of the parallel flash device on the far side of the controller.
`timescale 1ns/1ps
module flash_dev_model
    import flash_host_pkg::*;
// Boot block end; a non-uniform bottom part would protect up to 22'h001FFF.
#(parameter logic [21:0] BOOT_LAST = 22'h007FFF)(
    input  wire logic [21:0]        i_addr,
    input  wire logic [15:0]        i_dq,
    input  wire logic               i_ce_n,
    input  wire logic               i_we_n,
    input  wire logic               i_oe_n,
    input  wire logic               i_wp_n,
    input  wire logic               i_rst_n,
    input  wire logic signed [31:0] i_busy_reads,
    input  wire logic               i_abort_req,
    output logic [15:0]             o_dq,
    output logic                    o_rb_oe
);
    logic [15:0] mem[int];
    logic [15:0] q_r = 16'h0;
    int          step = 0;
    int          busy = 0;
    int          sh = -1;
    logic        tog = 0, abt = 0, ers = 0, pol = 0, lk;
    function automatic logic [15:0] rd(int a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_oe_n && i_rst_n) begin
            case (step)
                0, 3: step = (i_addr == UNLOCK_ADDR1 && i_dq[7:0] == 8'hAA) ? step + 1 : 0;
                1, 4: step = (i_addr == UNLOCK_ADDR2 && i_dq[7:0] == 8'h55) ? step + 1 : 0;
                2: begin
                    step = (i_dq[7:0] == 8'hA0) ? 6 : (i_dq[7:0] == 8'h80) ? 3 : 0;
                    if (i_dq[7:0] == 8'hF0) begin
                        busy = abt ? 0 : busy;
                        abt = 0;
                    end
                end
                6: begin
                    step = 0;
                    sh = 0;
                    lk = !i_wp_n && i_addr <= BOOT_LAST;
                    pol = ~i_dq[7];
                end
                default: begin
                    step = 0;
                    sh = (i_dq[7:0] == 8'h50) ? 12 : (i_dq[7:0] == 8'h30) ? 15 : (i_dq[7:0] == 8'h10) ? 22 : -1;
                    lk = !i_wp_n && (sh == 22 || i_addr <= BOOT_LAST);
                end
            endcase
            if (step == 0 && busy == 0 && sh >= 0) begin
                busy = lk ? 2 : i_abort_req ? -1 : i_busy_reads;
                abt = i_abort_req && !lk;
                ers = sh > 0;
                if (!lk && sh == 0) mem[i_addr] = rd(i_addr) & i_dq;
                if (!lk && sh > 0) foreach (mem[k]) if (((k ^ i_addr) >> sh) == 0) mem[k] = 16'hFFFF;
            end
            sh = -1;
        end
    end
    always @(negedge i_oe_n) begin
        if (!i_ce_n && busy != 0) begin
            tog = ~tog;
            q_r = {8'h00, ers ? 1'b0 : pol, tog, 3'b000, ers & tog, abt, 1'b0};
            busy = (busy > 0) ? busy - 1 : busy;
        end else if (!i_ce_n) q_r = rd(i_addr);
    end
    always @(negedge i_rst_n) begin
        busy = 0;
        abt = 0;
        step = 0;
    end
    assign o_rb_oe = (busy != 0);
    assign o_dq = (!i_ce_n && !i_oe_n) ? q_r : ~q_r;
endmodule : flash_dev_model

// ---- verification/testbench.sv ----
// Self-checking testbench of the flash host controller against the device model.
`timescale 1ns/1ps
module testbench;
    import flash_host_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m; string s;} note_t;
    logic        i_sys_clk = 0, i_rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, abort_req = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v, lfsr_r = 32'hA481;
    logic [15:0] dq_out, dq_dev, d;
    logic [21:0] f_addr;
    logic        dq_oe, ce_n, we_n, oe_n, wp_n, hw_rst_n, rb_oe;
    logic signed [31:0] busy_reads = 4;
    wire  [15:0] bus = dq_oe ? dq_out : dq_dev;
    wire         rb_n = !rb_oe;
    int          n_fail = 0, n_compared = 0;
    note_t       q[$];
    note_t       e;
    op_kind_t    kinds[3] = '{K_SECT, K_BLOCK, K_CHIP};
    initial forever #20 i_sys_clk = ~i_sys_clk;
    flash_host_ctrl #(.RESET_READ_CYCLES(10), .TIMEOUT_CYCLES(2000)) DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_dq(bus), .o_dq(dq_out), .o_dq_oe(dq_oe), .o_addr(f_addr), .o_ce_n(ce_n),
        .o_we_n(we_n), .o_oe_n(oe_n), .o_wp_n(wp_n), .o_hw_rst_n(hw_rst_n), .i_ready_busy_n(rb_n));
    flash_dev_model u_dev (.i_addr(f_addr), .i_dq(bus), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_wp_n(wp_n), .i_rst_n(hw_rst_n), .i_busy_reads(busy_reads), .i_abort_req(abort_req),
        .o_dq(dq_dev), .o_rb_oe(rb_oe));
    task automatic wr(logic [7:0] a, logic [31:0] w);
        @(posedge i_sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge i_sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] x, logic [31:0] m, string s);
        @(posedge i_sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        q.push_back('{x, m, s});
        @(posedge i_sys_clk);
        reg_rd <= 1'b0;
        @(posedge i_sys_clk);
        v = reg_rdata;
    endtask : rd
    // Polls until the done flag, then checks the sticky bits and clears them.
    task automatic op(op_kind_t k, logic [21:0] a, logic [15:0] w, logic [31:0] st);
        wr(REG_ADDR, {10'h0, a});
        wr(REG_DATA, {16'h0, w});
        wr(REG_CTRL, {29'h0, k});
        v = 32'h0;
        for (int i = 0; i < 400 && v[ST_DONE] !== 1'b1; i++) rd(REG_STATUS, 32'h0, 32'h0, "poll");
        rd(REG_STATUS, st, 32'h1F, "status");
        wr(REG_STATUS, 32'h1E);
    endtask : op
    task automatic chk(logic [21:0] a, logic [15:0] x);
        op(K_READ, a, 16'h0, 32'h2);
        rd(REG_DATA, {16'h0, x}, 32'hFFFF, "word");
    endtask : chk
    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    always @(posedge i_sys_clk) begin
        rd_d <= reg_rd;
        if (rd_d && q.size() > 0) begin
            e = q.pop_front();
            if (e.m != 0) begin
                n_compared++;
                if ((reg_rdata & e.m) !== (e.v & e.m)) begin
                    n_fail++;
                    $display("unexpected %s: expected %h, seen %h", e.s, e.v & e.m, reg_rdata & e.m);
                end
            end
        end
    end
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        n_fail++;
        results();
    end
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(REG_CFG, 32'h1, 32'hFFFFFFFF, "cfg");
        rd(REG_STATUS, 32'h60, 32'h7F, "status");
        rd(8'h14, 32'h0, 32'hFFFFFFFF, "unmapped");
        $display("test reset done");
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        d = lfsr_r[15:0];
        op(K_PROG, {8'h0, lfsr_r[29:16]}, d, 32'h2);
        chk({8'h0, lfsr_r[29:16]}, d);
        $display("test program done");
        wr(REG_CFG, 32'h0);
        rd(REG_STATUS, 32'h0, 32'h40, "protect pin");
        op(K_PROG, 22'h007FFF, d, 32'h2);
        chk(22'h007FFF, 16'hFFFF);
        op(K_PROG, 22'h008000, d, 32'h2);
        chk(22'h008000, d);
        op(K_SECT, {8'h0, lfsr_r[29:16]}, 16'h0, 32'h2);
        chk({8'h0, lfsr_r[29:16]}, d);
        wr(REG_CFG, 32'h1);
        $display("test protect done");
        foreach (kinds[i]) begin
            op(K_PROG, 22'h000100, d, 32'h2);
            op(kinds[i], 22'h000100, 16'h0, 32'h2);
            chk(22'h000100, 16'hFFFF);
        end
        $display("test erase done");
        abort_req = 1'b1;
        op(K_PROG, 22'h010000, d, 32'h6);
        abort_req = 1'b0;
        rd(REG_STATUS, 32'h20, 32'h3F, "abort cleared");
        $display("test abort done");
        busy_reads = -1;
        wr(REG_ADDR, 32'h0002_0000);
        wr(REG_CTRL, {29'h0, K_PROG});
        repeat (300) @(posedge i_sys_clk);
        rd(REG_STATUS, 32'h1, 32'h21, "busy pin");
        op(K_HWRST, 22'h020000, d, 32'h12);
        busy_reads = 4;
        rd(REG_STATUS, 32'h20, 32'h20, "ready pin");
        $display("test hardware reset done");
        results();
    end
endmodule : testbench
